// file: dso_core.v
// drive status outputs, level comparators and fault reset handling
// What this block does
// - ready when idle and not faulted
// - running needs run, no dc injection, no fault
// - at speed when output equals nonzero reference
// - command source high for keypad
// - mode output high in automatic
// - current limit output follows limit reached
// - fault function outputs; fixed relay de-energizes
// - thermal alarm 60 s ahead, large ratings
// - loss of follower below 3 mA
// - frequency level set above, clear below
// - current level 10 to 110 percent
// - thermal level 0 to 200 percent
// - function to many outputs; bound outputs locked
// - any fault switches power stage off
// - power off over 1 s resets all
// - long phase failure may act likewise
// - no reset while cause persists
// - hardware faults clear only by power removal
// - process faults clear by input or key
// - auto restart 2-wire only, not serial link
// - undervoltage and phase failure never latch
`timescale 1ns/1ps
`default_nettype none
`include "dso_consts.vh"
module dso_core #(
  parameter LARGE_RATING = 1,
  parameter OUTAGE_CYC   = `DSO_CLK_HZ / 1000 * `DSO_OUTAGE_MS,
  parameter TICK_CYC     = `DSO_CLK_HZ / 1000 * `DSO_TICK_MS
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // avalon-mm slave
  input  wire [5:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // drive control core state
  input  wire        run_cmd_i,
  input  wire        dc_inj_i,
  input  wire        bypass_en_i,
  input  wire        seq_in_i,
  input  wire        keypad_cmd_i,
  input  wire        auto_mode_i,
  input  wire        cur_limit_i,
  input  wire [9:0]  freq_out_i,
  input  wire [9:0]  freq_ref_i,
  input  wire [7:0]  current_pct_i,
  input  wire [7:0]  motor_therm_pct_i,
  input  wire [9:0]  drv_trip_eta_s_i,
  input  wire [7:0]  second_analog_current_input_i,
  input  wire [22:0] fault_cond_i,
  // plant pins
  input  wire        pwr_ok_i,
  input  wire        phase_fail_i,
  input  wire        assignable_logic_input_i,
  // outputs
  output wire [3:0]  assignable_logic_output_o,
  output wire [3:0]  assignable_relay_output_o,
  output wire        dedicated_fault_relay_o,
  output wire        pwr_stage_en_o
);
  localparam AR_IDLE = 2'b00;
  localparam AR_WAIT = 2'b01;
  localparam AR_LOCK = 2'b10;
  localparam integer OUT_N  = OUTAGE_CYC;
  localparam integer TICK_N = TICK_CYC;
  localparam [24:0] OUT_LIM  = OUT_N[24:0];
  localparam [24:0] TICK_LIM = TICK_N[24:0];

  // registers
  reg [7:0]  ctrl_reg;
  reg [9:0]  adly_reg;
  reg [9:0]  flvl_reg;
  reg [7:0]  clvl_reg;
  reg [7:0]  tlvl_reg;
  reg [31:0] asgn_reg;
  reg [7:0]  bind_reg;
  reg        ack_reg;
  reg [31:0] rdata_reg;
  reg        fkey_reg;
  // pin synchronisers
  reg [1:0]  pwr_s_reg;
  reg [1:0]  ph_s_reg;
  reg [1:0]  li_s_reg;
  reg        li_d_reg;
  // fault state
  reg [22:0] flt_reg;
  reg [24:0] out_cnt_reg;
  reg        man_rst_reg;
  reg        nl_hold_reg;
  reg [24:0] tick_cnt_reg;
  reg        tick_reg;
  reg [1:0]  ar_state_reg;
  reg [1:0]  ar_state_next;
  reg [9:0]  ar_dly_reg;
  reg [2:0]  ar_tries_reg;
  reg        ar_clr;
  // outputs
  reg [7:0]  out_reg;
  reg        relay_reg;
  reg        pwr_en_reg;
  wire       fault_any;

  wire        req      = avs_read_i | avs_write_i;
  wire        wr_en    = avs_write_i & ack_reg;
  wire [5:0]  word_a   = {avs_address_i[5:2], 2'b00};
  wire [31:0] be_mask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                          {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] m;
    begin
      merge = (old_v & ~m) | (new_v & m);
    end
  endfunction

  // merged write values, clamped to the settable ranges
  wire [31:0] ctrl_w = merge({24'h000000, ctrl_reg}, avs_writedata_i, be_mask);
  wire [31:0] adly_w = merge({22'h000000, adly_reg}, avs_writedata_i, be_mask);
  wire [31:0] flvl_w = merge({22'h000000, flvl_reg}, avs_writedata_i, be_mask);
  wire [31:0] clvl_w = merge({24'h000000, clvl_reg}, avs_writedata_i, be_mask);
  wire [31:0] tlvl_w = merge({24'h000000, tlvl_reg}, avs_writedata_i, be_mask);
  wire [31:0] asgn_w = merge(asgn_reg, avs_writedata_i, be_mask);
  wire [2:0]  cnt_w  = ctrl_w[`DSO_CTRL_CNT_HI:`DSO_CTRL_CNT_LO];
  wire [2:0]  cnt_c  = (cnt_w < `DSO_CNT_MIN) ? `DSO_CNT_MIN :
                       (cnt_w > `DSO_CNT_MAX) ? `DSO_CNT_MAX : cnt_w;
  wire [31:0] asgn_lock;
  wire [2:0]  bind_idx = avs_writedata_i[`DSO_BIND_IDX_HI:`DSO_BIND_IDX_LO];

  wire two_wire = ctrl_reg[`DSO_CTRL_2WIRE];
  wire ar_en    = ctrl_reg[`DSO_CTRL_AREN];
  wire ph_en    = ctrl_reg[`DSO_CTRL_PHEN];
  wire ai2_ma   = ctrl_reg[`DSO_CTRL_AI2MA];

  // avalon slave: one wait state, write lands on the edge waitrequest is low
  assign avs_waitrequest_o = req & ~ack_reg;
  assign avs_readdata_o    = rdata_reg;

  genvar g;
  generate
    for (g = 0; g < `DSO_NOUT; g = g + 1) begin : g_lock
      assign asgn_lock[4*g+3:4*g] = {4{bind_reg[g]}};
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      ctrl_reg <= `DSO_RST_CTRL;
      adly_reg <= `DSO_RST_ADLY;
      flvl_reg <= `DSO_RST_FLVL;
      clvl_reg <= `DSO_RST_CLVL;
      tlvl_reg <= `DSO_RST_TLVL;
      asgn_reg <= `DSO_RST_ASGN;
      bind_reg <= 8'h00;
      fkey_reg <= 1'b0;
    end else begin
      ack_reg  <= req & ~ack_reg;
      fkey_reg <= 1'b0;
      if (wr_en) begin
        case (word_a)
          `DSO_OFF_CTRL: begin
            ctrl_reg <= {ctrl_w[7], 1'b0, ctrl_w[5], cnt_c, ctrl_w[1:0]};
            fkey_reg <= ctrl_w[`DSO_CTRL_FKEY] & avs_byteenable_i[0];
          end
          `DSO_OFF_ADLY: adly_reg <= (adly_w[9:0] < `DSO_ADLY_MIN) ? `DSO_ADLY_MIN :
                                     (adly_w[9:0] > `DSO_ADLY_MAX) ? `DSO_ADLY_MAX : adly_w[9:0];
          `DSO_OFF_FLVL: flvl_reg <= (flvl_w[9:0] > `DSO_FLVL_MAX) ? `DSO_FLVL_MAX : flvl_w[9:0];
          `DSO_OFF_CLVL: clvl_reg <= (clvl_w[7:0] < `DSO_CLVL_MIN) ? `DSO_CLVL_MIN :
                                     (clvl_w[7:0] > `DSO_CLVL_MAX) ? `DSO_CLVL_MAX : clvl_w[7:0];
          `DSO_OFF_TLVL: tlvl_reg <= (tlvl_w[7:0] > `DSO_TLVL_MAX) ? `DSO_TLVL_MAX : tlvl_w[7:0];
          `DSO_OFF_ASGN: asgn_reg <= (asgn_reg & asgn_lock) | (asgn_w & ~asgn_lock);
          `DSO_OFF_BIND: begin
            asgn_reg[bind_idx*4 +: 4] <= avs_writedata_i[`DSO_BIND_FN_HI:`DSO_BIND_FN_LO];
            bind_reg[bind_idx]        <= avs_writedata_i[`DSO_BIND_EN];
          end
          default: ;
        endcase
      end
    end
  end

  // read data is captured in the wait cycle so it stands at the accept edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h00000000;
    end else if (avs_read_i & ~ack_reg) begin
      case (word_a)
        `DSO_OFF_CTRL: rdata_reg <= {24'h000000, ctrl_reg};
        `DSO_OFF_ADLY: rdata_reg <= {22'h000000, adly_reg};
        `DSO_OFF_FLVL: rdata_reg <= {22'h000000, flvl_reg};
        `DSO_OFF_CLVL: rdata_reg <= {24'h000000, clvl_reg};
        `DSO_OFF_TLVL: rdata_reg <= {24'h000000, tlvl_reg};
        `DSO_OFF_ASGN: rdata_reg <= asgn_reg;
        `DSO_OFF_BIND: rdata_reg <= {24'h000000, bind_reg};
        `DSO_OFF_FLT:  rdata_reg <= {9'h000, flt_reg | (fault_cond_i & `DSO_NL_MASK)};
        `DSO_OFF_STAT: rdata_reg <= {15'h0000, nl_hold_reg, ar_tries_reg, ar_state_reg,
                                     relay_reg, pwr_en_reg, fault_any, out_reg};
        default:       rdata_reg <= 32'h00000000;
      endcase
    end
  end

  // pins cross into the clock domain through two flops before use
  always @(posedge clk_i) begin
    if (rst_i) begin
      pwr_s_reg <= 2'b00;
      ph_s_reg  <= 2'b00;
      li_s_reg  <= 2'b00;
      li_d_reg  <= 1'b0;
    end else begin
      pwr_s_reg <= {pwr_s_reg[0], pwr_ok_i};
      ph_s_reg  <= {ph_s_reg[0], phase_fail_i};
      li_s_reg  <= {li_s_reg[0], assignable_logic_input_i};
      li_d_reg  <= li_s_reg[1];
    end
  end

  wire outage   = ~pwr_s_reg[1] | (ph_en & ph_s_reg[1]);
  wire out_full = (out_cnt_reg == OUT_LIM);
  wire li_rst   = (li_s_reg[1] & ~li_d_reg) | fkey_reg;

  // outage timer; the manual reset fires when supply returns after the limit
  always @(posedge clk_i) begin
    if (rst_i) begin
      out_cnt_reg <= 25'h0000000;
      man_rst_reg <= 1'b0;
    end else begin
      man_rst_reg <= ~outage & out_full;
      if (~outage) begin
        out_cnt_reg <= 25'h0000000;
      end else if (~out_full) begin
        out_cnt_reg <= out_cnt_reg + 25'h0000001;
      end
    end
  end

  // one-second tick for the restart delay
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 25'h0000000;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == TICK_LIM - 25'h0000001);
      if (tick_cnt_reg == TICK_LIM - 25'h0000001) begin
        tick_cnt_reg <= 25'h0000000;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 25'h0000001;
      end
    end
  end

  // fault latch: a clear only reaches bits whose cause has gone
  wire [22:0] clr_mask = ({23{man_rst_reg}} |
                          ({23{li_rst}} & `DSO_PROC_MASK) |
                          ({23{ar_clr}} & `DSO_AUTO_MASK)) & ~fault_cond_i;
  wire [22:0] nl_act   = fault_cond_i & `DSO_NL_MASK;
  assign fault_any = (|flt_reg) | (|nl_act);

  always @(posedge clk_i) begin
    if (rst_i) begin
      flt_reg <= 23'h000000;
    end else begin
      // set wins over clear in the same cycle
      flt_reg <= (flt_reg & ~clr_mask) | (fault_cond_i & ~`DSO_NL_MASK);
    end
  end

  // auto restart is offered only when every latched fault is auto-resettable
  wire ar_go = two_wire & ar_en & (|(flt_reg & `DSO_AUTO_MASK)) &
               ~(|(flt_reg & ~`DSO_AUTO_MASK));
  wire ar_due = tick_reg & (ar_dly_reg + 10'h001 >= adly_reg);
  wire ar_ok  = ~(|(fault_cond_i & flt_reg & `DSO_AUTO_MASK));

  always @* begin
    ar_state_next = ar_state_reg;
    ar_clr        = 1'b0;
    case (ar_state_reg)
      AR_IDLE: if (ar_go) ar_state_next = AR_WAIT;
      AR_WAIT: begin
        if (~ar_go) begin
          ar_state_next = AR_IDLE;
        end else if (ar_due & ar_ok) begin
          ar_clr        = 1'b1;
          ar_state_next = AR_IDLE;
        end else if (ar_due & (ar_tries_reg == 3'h1)) begin
          ar_state_next = AR_LOCK;
        end
      end
      AR_LOCK: if (~(|flt_reg)) ar_state_next = AR_IDLE;
      default: ar_state_next = AR_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ar_state_reg <= AR_IDLE;
      ar_dly_reg   <= 10'h000;
      ar_tries_reg <= 3'h0;
    end else begin
      ar_state_reg <= ar_state_next;
      if (ar_state_reg != AR_WAIT) begin
        ar_dly_reg   <= 10'h000;
        ar_tries_reg <= ctrl_reg[`DSO_CTRL_CNT_HI:`DSO_CTRL_CNT_LO];
      end else if (ar_due) begin
        ar_dly_reg   <= 10'h000;
        ar_tries_reg <= ar_tries_reg - 3'h1;
      end else if (tick_reg) begin
        ar_dly_reg <= ar_dly_reg + 10'h001;
      end
    end
  end

  // under 3-wire a cleared non-latching fault still needs a fresh run command
  always @(posedge clk_i) begin
    if (rst_i) begin
      nl_hold_reg <= 1'b0;
    end else if ((|nl_act) & ~two_wire) begin
      nl_hold_reg <= 1'b1;
    end else if (~run_cmd_i) begin
      nl_hold_reg <= 1'b0;
    end
  end

  // level comparators
  wire flvl_hit;
  wire clvl_hit;
  wire tlvl_hit;

  dso_level_cmp #(.SET_ON_EQ(0)) u_flvl (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .value_i (freq_out_i),
    .level_i (flvl_reg),
    .above_o (flvl_hit)
  );

  dso_level_cmp #(.SET_ON_EQ(0)) u_clvl (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .value_i ({2'b00, current_pct_i}),
    .level_i ({2'b00, clvl_reg}),
    .above_o (clvl_hit)
  );

  dso_level_cmp #(.SET_ON_EQ(1)) u_tlvl (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .value_i ({2'b00, motor_therm_pct_i}),
    .level_i ({2'b00, tlvl_reg}),
    .above_o (tlvl_hit)
  );

  // function vector indexed by the output function code
  wire [15:0] fn_vec;
  assign fn_vec[`DSO_FN_NONE]  = 1'b0;
  assign fn_vec[`DSO_FN_READY] = ~run_cmd_i & ~fault_any;
  assign fn_vec[`DSO_FN_RUN]   = run_cmd_i & ~dc_inj_i & ~fault_any & (~bypass_en_i | seq_in_i);
  assign fn_vec[`DSO_FN_ATSPD] = run_cmd_i & (freq_ref_i != 10'h000) & (freq_out_i == freq_ref_i);
  assign fn_vec[`DSO_FN_KEYPD] = keypad_cmd_i;
  assign fn_vec[`DSO_FN_AUTO]  = auto_mode_i;
  assign fn_vec[`DSO_FN_ILIM]  = cur_limit_i;
  assign fn_vec[`DSO_FN_FAULT] = fault_any;
  assign fn_vec[`DSO_FN_THALM] = (LARGE_RATING != 0) & (drv_trip_eta_s_i <= `DSO_THALM_S);
  assign fn_vec[`DSO_FN_LOF]   = ai2_ma & (second_analog_current_input_i < `DSO_LOF_LVL);
  assign fn_vec[`DSO_FN_FLVL]  = flvl_hit;
  assign fn_vec[`DSO_FN_CLVL]  = clvl_hit;
  assign fn_vec[`DSO_FN_TLVL]  = tlvl_hit;
  assign fn_vec[15:13]         = 3'b000;

  // each output picks its function; codes may repeat across outputs
  wire [7:0] out_next;
  generate
    for (g = 0; g < `DSO_NOUT; g = g + 1) begin : g_out
      assign out_next[g] = fn_vec[asgn_reg[4*g+3:4*g]];
    end
  endgenerate

  // relay starts de-energized: a reset drive shows as faulted until evaluated
  always @(posedge clk_i) begin
    if (rst_i) begin
      out_reg    <= 8'h00;
      relay_reg  <= 1'b0;
      pwr_en_reg <= 1'b0;
    end else begin
      out_reg    <= out_next;
      relay_reg  <= ~fault_any;
      pwr_en_reg <= run_cmd_i & ~fault_any & ~outage & ~nl_hold_reg;
    end
  end

  assign assignable_logic_output_o = out_reg[3:0];
  assign assignable_relay_output_o = out_reg[7:4];
  assign dedicated_fault_relay_o   = relay_reg;
  assign pwr_stage_en_o            = pwr_en_reg;
endmodule // dso_core
`default_nettype wire

// file: dso_consts.vh
// constants for the drive status output and fault reset block
`ifndef DSO_CONSTS_VH
`define DSO_CONSTS_VH
// register byte offsets
`define DSO_OFF_CTRL  6'h00
`define DSO_OFF_ADLY  6'h04
`define DSO_OFF_FLVL  6'h08
`define DSO_OFF_CLVL  6'h0C
`define DSO_OFF_TLVL  6'h10
`define DSO_OFF_ASGN  6'h14
`define DSO_OFF_BIND  6'h18
`define DSO_OFF_FLT   6'h1C
`define DSO_OFF_STAT  6'h20
// control register fields
`define DSO_CTRL_2WIRE  0
`define DSO_CTRL_AREN   1
`define DSO_CTRL_CNT_LO 2
`define DSO_CTRL_CNT_HI 4
`define DSO_CTRL_PHEN   5
`define DSO_CTRL_FKEY   6
`define DSO_CTRL_AI2MA  7
// bind register fields
`define DSO_BIND_FN_LO  0
`define DSO_BIND_FN_HI  3
`define DSO_BIND_IDX_LO 8
`define DSO_BIND_IDX_HI 10
`define DSO_BIND_EN     15
// reset values
`define DSO_RST_CTRL 8'h04
`define DSO_RST_ADLY 10'h001
`define DSO_RST_FLVL 10'h000
`define DSO_RST_CLVL 8'h6E
`define DSO_RST_TLVL 8'h64
`define DSO_RST_ASGN 32'h00000000
// setting limits (frequency in 0.1 Hz, current input in 0.1 mA)
`define DSO_FLVL_MAX 10'h2D0
`define DSO_CLVL_MIN 8'h0A
`define DSO_CLVL_MAX 8'h6E
`define DSO_TLVL_MAX 8'hC8
`define DSO_ADLY_MIN 10'h001
`define DSO_ADLY_MAX 10'h258
`define DSO_CNT_MIN  3'h1
`define DSO_CNT_MAX  3'h5
`define DSO_LOF_LVL  8'h1E
`define DSO_THALM_S  10'h03C
// timing
`define DSO_CLK_HZ    25000000
`define DSO_OUTAGE_MS 1000
`define DSO_TICK_MS   1000
// output function codes
`define DSO_FN_NONE  4'h0
`define DSO_FN_READY 4'h1
`define DSO_FN_RUN   4'h2
`define DSO_FN_ATSPD 4'h3
`define DSO_FN_KEYPD 4'h4
`define DSO_FN_AUTO  4'h5
`define DSO_FN_ILIM  4'h6
`define DSO_FN_FAULT 4'h7
`define DSO_FN_THALM 4'h8
`define DSO_FN_LOF   4'h9
`define DSO_FN_FLVL  4'hA
`define DSO_FN_CLVL  4'hB
`define DSO_FN_TLVL  4'hC
// fault classes: bits 0-10 hardware, 11-20 process, 20 serial link, 21-22 non-latching
`define DSO_NFLT      23
`define DSO_HW_MASK   23'h0007FF
`define DSO_PROC_MASK 23'h1FF800
`define DSO_AUTO_MASK 23'h0FF800
`define DSO_NL_MASK   23'h600000
`define DSO_NOUT      8
`endif

// file: dso_level_cmp.v
// level comparator with set-above, clear-below holding
`timescale 1ns/1ps
`default_nettype none
module dso_level_cmp #(
  parameter SET_ON_EQ = 0
) (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // compare
  input  wire [9:0] value_i,
  input  wire [9:0] level_i,
  output wire       above_o
);
  reg above_reg;
  wire set_w = (SET_ON_EQ != 0) ? (value_i >= level_i) : (value_i > level_i);

  // between set and clear the output holds; equality holds it unless SET_ON_EQ is set, then it sets
  always @(posedge clk_i) begin
    if (rst_i) begin
      above_reg <= 1'b0;
    end else if (set_w) begin
      above_reg <= 1'b1;
    end else if (value_i < level_i) begin
      above_reg <= 1'b0;
    end
  end

  assign above_o = above_reg;
endmodule // dso_level_cmp
`default_nettype wire

// file: dso_core_asserts.sv
// assertion checker for the drive status output block
`timescale 1ns/1ps
`default_nettype none
module dso_core_asserts (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // fault path
  input wire logic [22:0] fault_cond_i,
  input wire logic        dedicated_fault_relay_o,
  input wire logic        pwr_stage_en_o
);
  wire logic req;
  assign req = avs_read_i | avs_write_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req_start;
    req && !$past(req);
  endsequence
  sequence s_req_waiting;
    req && avs_waitrequest_o ##1 req;
  endsequence
  // three samples give the latch and the output flop time to act
  sequence s_cause_held;
    (|fault_cond_i[20:0]) [*3];
  endsequence
  chk_wait_first: assert property (s_req_start |-> avs_waitrequest_o) else $error("new request without wait state");
  chk_wait_single: assert property (s_req_waiting |-> !avs_waitrequest_o) else $error("more than one wait state");
  chk_wait_idle: assert property (!req |-> !avs_waitrequest_o) else $error("wait asserted with no request");
  chk_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o)) else $error("read data moved without read");
  chk_relay_trip: assert property ((|fault_cond_i[20:0]) |-> ##[1:3] !dedicated_fault_relay_o)
    else $error("fault relay stayed energized on fault");
  chk_power_trip: assert property ((|fault_cond_i) |-> ##[1:3] !pwr_stage_en_o)
    else $error("power stage stayed on during fault");
  chk_cause_blocks: assert property (s_cause_held |-> !dedicated_fault_relay_o)
    else $error("fault cleared while cause present");
  chk_power_relay: assert property (pwr_stage_en_o |-> dedicated_fault_relay_o)
    else $error("power stage on while faulted");
endmodule // dso_core_asserts
bind dso_core dso_core_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .fault_cond_i(fault_cond_i),
  .dedicated_fault_relay_o(dedicated_fault_relay_o), .pwr_stage_en_o(pwr_stage_en_o));
`default_nettype wire

// file: dso_plant.sv
// plant wiring model: mains supply, phase monitor and reset push button
`timescale 1ns/1ps
`default_nettype none
module dso_plant (
  // clock
  input  wire logic clk_i,
  // bench commands
  input  wire logic outage_i,
  input  wire logic phase_loss_i,
  input  wire logic press_i,
  // pins toward the drive
  output var logic  pwr_ok_o,
  output var logic  phase_fail_o,
  output var logic  reset_button_o
);
  initial begin
    pwr_ok_o = 1'b1;
    phase_fail_o = 1'b0;
    reset_button_o = 1'b0;
  end
  // pins move after the edge so the drive's synchronizer never sees a race
  always @(posedge clk_i) begin
    pwr_ok_o <= !outage_i;
    phase_fail_o <= phase_loss_i;
    reset_button_o <= press_i;
  end
endmodule // dso_plant
`default_nettype wire

// file: tb_drive_status_outputs_fault_reset.sv
// self-checking bench for the drive status output block
`timescale 1ns/1ps
`default_nettype none
`include "dso_consts.vh"
module tb_drive_status_outputs_fault_reset;
  logic             clk_i = 1'b0, rst_i = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [5:0]       adr = 6'h00;
  logic [31:0]      wdat = 32'h0, asg = 32'h0;
  logic             run = 1'b0, dci = 1'b0, byp = 1'b0, seq = 1'b0, kp = 1'b0, am = 1'b0, il = 1'b0;
  logic [9:0]       fo = 10'h0, fr = 10'h0, eta = 10'h3FF, v;
  logic [7:0]       cur = 8'h0, th = 8'h0, ai2 = 8'hFF;
  logic [22:0]      fc = 23'h0;
  logic             outage = 1'b0, phl = 1'b0, press = 1'b0, fl_s = 1'b0, cl_s = 1'b0, tl_s = 1'b0;
  logic [31:0]      rdq [$];
  int               failures = 0;
  int               checks = 0;
  wire logic [31:0] rdat;
  wire logic        wreq, pok, pfl, btn, frel, pen;
  wire logic [3:0]  lo, ro;
  wire logic [7:0]  outs;
  assign outs = {ro, lo};
  always #20 clk_i = ~clk_i;
  // short outage and tick counts keep the run brief
  dso_core #(.OUTAGE_CYC(40), .TICK_CYC(20)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .run_cmd_i(run), .dc_inj_i(dci), .bypass_en_i(byp), .seq_in_i(seq), .keypad_cmd_i(kp),
    .auto_mode_i(am), .cur_limit_i(il), .freq_out_i(fo), .freq_ref_i(fr), .current_pct_i(cur),
    .motor_therm_pct_i(th), .drv_trip_eta_s_i(eta), .second_analog_current_input_i(ai2),
    .fault_cond_i(fc), .pwr_ok_i(pok), .phase_fail_i(pfl), .assignable_logic_input_i(btn),
    .assignable_logic_output_o(lo), .assignable_relay_output_o(ro), .dedicated_fault_relay_o(frel),
    .pwr_stage_en_o(pen));
  dso_plant PLANT (.clk_i(clk_i), .outage_i(outage), .phase_loss_i(phl), .press_i(press),
    .pwr_ok_o(pok), .phase_fail_o(pfl), .reset_button_o(btn));
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic miss(input logic [31:0] got, input logic [31:0] exp);
    failures++;
    $display("mismatch at %0t got %h expected %h", $time, got, exp);
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) miss(got, exp);
  endtask
  task automatic cmp_pin(input logic got, input logic exp);
    checks++;
    if (got !== exp) miss({31'h0, got}, {31'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    wr <= 1'b0;
    rd <= 1'b0;
    if (n == 50) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic rdx(input logic [5:0] a, input logic [31:0] e);
    rdq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wrx(input logic [5:0] a, input logic [31:0] d, input logic [31:0] e);
    bus(1'b1, a, d);
    rdx(a, e);
  endtask
  // the button is held long enough to pass the two-flop synchronizer
  task automatic button();
    press <= 1'b1;
    tick(8);
    press <= 1'b0;
    tick(8);
  endtask
  always @(posedge clk_i) begin
    if (rd && wreq === 1'b0) begin
      if (rdq.size() == 0)
        miss(rdat, 32'h0);
      else
        cmp_reg(rdat, rdq.pop_front());
    end
  end
  function automatic logic fexp(input logic [3:0] c);
    case (c)
      `DSO_FN_READY: return !run;
      `DSO_FN_RUN:   return run && !dci && (!byp || seq);
      `DSO_FN_ATSPD: return run && fr != 10'h0 && fo == fr;
      `DSO_FN_KEYPD: return kp;
      `DSO_FN_AUTO:  return am;
      `DSO_FN_ILIM:  return il;
      `DSO_FN_THALM: return eta <= `DSO_THALM_S;
      `DSO_FN_LOF:   return ai2 < `DSO_LOF_LVL;
      `DSO_FN_FLVL:  return fl_s;
      `DSO_FN_CLVL:  return cl_s;
      `DSO_FN_TLVL:  return tl_s;
      default:       return 1'b0;
    endcase
  endfunction
  initial begin
    void'($urandom(5642));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(2);
    rdx(`DSO_OFF_CTRL, 32'h04);
    rdx(`DSO_OFF_ADLY, 32'h001);
    rdx(`DSO_OFF_FLVL, 32'h000);
    rdx(`DSO_OFF_CLVL, 32'h6E);
    rdx(`DSO_OFF_TLVL, 32'h64);
    rdx(`DSO_OFF_ASGN, 32'h0);
    wrx(6'h24, 32'hFFFFFFFF, 32'h0);
    wrx(`DSO_OFF_FLVL, 32'h3FF, 32'h2D0);
    wrx(`DSO_OFF_CLVL, 32'h05, 32'h0A);
    wrx(`DSO_OFF_CLVL, 32'hFF, 32'h6E);
    wrx(`DSO_OFF_TLVL, 32'hFF, 32'hC8);
    wrx(`DSO_OFF_ADLY, 32'h3FF, 32'h258);
    wrx(`DSO_OFF_ADLY, 32'h0, 32'h001);
    wrx(`DSO_OFF_FLVL, 32'h12C, 32'h12C);
    wrx(`DSO_OFF_CLVL, 32'h32, 32'h32);
    wrx(`DSO_OFF_TLVL, 32'h78, 32'h78);
    wrx(`DSO_OFF_CTRL, 32'h85, 32'h85);
    $display("test registers done");
    for (int i = 0; i < 48; i++) begin
      if (i % 24 == 0) begin
        asg = (i == 0) ? 32'h87654321 : 32'h1CBA9CBA;
        bus(1'b1, `DSO_OFF_ASGN, asg);
      end
      v = (i % 8 == 0) ? 10'h0 : 10'($urandom_range(720));
      {run, dci, byp, seq, kp, am, il} <= 7'($urandom);
      fr <= v;
      fo <= (i % 3 == 0) ? 10'($urandom_range(720)) : v;
      cur <= 8'($urandom_range(150));
      th <= 8'($urandom);
      ai2 <= 8'($urandom_range(60));
      eta <= 10'($urandom_range(120));
      tick(4);
      fl_s = (fo > 10'h12C) ? 1'b1 : (fo < 10'h12C) ? 1'b0 : fl_s;
      cl_s = (cur > 8'h32) ? 1'b1 : (cur < 8'h32) ? 1'b0 : cl_s;
      tl_s = (th >= 8'h78);
      for (int k = 0; k < 8; k++)
        cmp_pin(outs[k], fexp(asg[4*k +: 4]));
      cmp_pin(frel, 1'b1);
      cmp_pin(pen, run);
    end
    $display("test output functions done");
    asg = 32'h87654321;
    bus(1'b1, `DSO_OFF_ASGN, asg);
    fc <= 23'h000800;
    tick(4);
    cmp_pin(frel, 1'b0);
    cmp_pin(pen, 1'b0);
    cmp_pin(outs[6], 1'b1);
    button();
    rdx(`DSO_OFF_FLT, 32'h800);
    fc <= 23'h0;
    tick(2);
    rdx(`DSO_OFF_FLT, 32'h800);
    button();
    rdx(`DSO_OFF_FLT, 32'h0);
    cmp_pin(frel, 1'b1);
    fc <= 23'h001000;
    tick(2);
    fc <= 23'h0;
    rdx(`DSO_OFF_FLT, 32'h1000);
    wrx(`DSO_OFF_CTRL, 32'hC5, 32'h85);
    rdx(`DSO_OFF_FLT, 32'h0);
    $display("test process faults done");
    // first pass is an outage too short to count as a power removal
    bus(1'b1, `DSO_OFF_CTRL, 32'hA5);
    for (int m = 0; m < 3; m++) begin
      fc <= 23'h000001;
      tick(2);
      fc <= 23'h0;
      button();
      rdx(`DSO_OFF_FLT, 32'h1);
      outage <= (m < 2);
      phl <= (m == 2);
      tick(m == 0 ? 30 : 50);
      outage <= 1'b0;
      phl <= 1'b0;
      tick(10);
      rdx(`DSO_OFF_FLT, (m == 0) ? 32'h1 : 32'h0);
    end
    fc <= 23'h200000;
    tick(4);
    cmp_pin(pen, 1'b0);
    rdx(`DSO_OFF_FLT, 32'h200000);
    fc <= 23'h0;
    tick(4);
    rdx(`DSO_OFF_FLT, 32'h0);
    $display("test manual reset done");
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, `DSO_OFF_CTRL, (m == 2) ? 32'h86 : 32'h87);
      fc <= (m == 1) ? 23'h100000 : 23'h002000;
      tick(2);
      fc <= 23'h0;
      tick(100);
      rdx(`DSO_OFF_FLT, (m == 0) ? 32'h0 : ((m == 1) ? 32'h100000 : 32'h2000));
      button();
    end
    // under 3-wire a cleared undervoltage keeps the stage off until run drops
    run <= 1'b1;
    fc <= 23'h200000;
    tick(2);
    fc <= 23'h0;
    tick(4);
    cmp_pin(pen, 1'b0);
    run <= 1'b0;
    tick(2);
    run <= 1'b1;
    tick(4);
    cmp_pin(pen, 1'b1);
    $display("test auto restart done");
    bus(1'b1, `DSO_OFF_BIND, 32'h00008001);
    wrx(`DSO_OFF_ASGN, 32'h00000007, 32'h00000001);
    rdx(`DSO_OFF_BIND, 32'h00000001);
    $display("test binding done");
    tick(4);
    stop_test();
  end
endmodule // tb_drive_status_outputs_fault_reset
`default_nettype wire
